// ### rtl/rx_filt_pkg.sv
`default_nettype none
package rx_filt_pkg;
  // Timing
  localparam int unsigned CLK_MHZ        = 200;
  localparam int unsigned TURNAROUND_US  = 192;
  localparam int unsigned TURNAROUND_CYC = TURNAROUND_US * CLK_MHZ;

  // Register byte addresses
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_DEMOD  = 8'h04;
  localparam logic [7:0] ADR_FILT0  = 8'h08;
  localparam logic [7:0] ADR_FILT1  = 8'h0c;
  localparam logic [7:0] ADR_PANID  = 8'h10;
  localparam logic [7:0] ADR_SHORT  = 8'h14;
  localparam logic [7:0] ADR_EXTLO  = 8'h18;
  localparam logic [7:0] ADR_EXTHI  = 8'h1c;
  localparam logic [7:0] ADR_STATUS = 8'h20;
  localparam logic [7:0] ADR_EVENT  = 8'h24;
  localparam logic [7:0] ADR_ROUTE  = 8'h28;

  // Field positions
  localparam int unsigned CTRL_RXEN_B  = 0;
  localparam int unsigned CTRL_SKIP_B  = 1;
  localparam int unsigned DEM_THR_LSB  = 0;
  localparam int unsigned DEM_PRE_LSB  = 8;
  localparam int unsigned F0_EN_B      = 0;
  localparam int unsigned F0_COORD_B   = 1;
  localparam int unsigned F0_MASK_LSB  = 2;
  localparam int unsigned F0_VER_LSB   = 5;
  localparam int unsigned F1_ACC_LSB   = 0;
  localparam int unsigned F1_OVR_LSB   = 5;
  localparam int unsigned EV_SFD_B     = 0;
  localparam int unsigned EV_ACC_B     = 1;

  // Reset values
  localparam logic       RST_RXEN  = 1'b0;
  localparam logic       RST_SKIP  = 1'b1;
  localparam logic [7:0] RST_THR   = 8'h14;
  localparam logic [3:0] RST_PRE   = 4'h0;
  localparam logic       RST_FEN   = 1'b1;
  localparam logic       RST_COORD = 1'b0;
  localparam logic [2:0] RST_MASK  = 3'h7;
  localparam logic [1:0] RST_VER   = 2'h3;
  localparam logic [4:0] RST_ACC   = 5'h0f;
  localparam logic [1:0] RST_OVR   = 2'h0;
  localparam logic [2:0] RST_ROUTE = 3'h1;

  // Frame constants
  localparam logic [15:0] BCAST     = 16'hffff;
  localparam logic [6:0]  LEN_MIN   = 7'h09;
  localparam logic [6:0]  LEN_ACK   = 7'h05;
  localparam logic [6:0]  HDR_BYTES = 7'h17;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SEARCH = 5'b00010,
    ST_LEN    = 5'b00100,
    ST_BODY   = 5'b01000,
    ST_DROP   = 5'b10000
  } rx_state_t;
endpackage : rx_filt_pkg
`default_nettype wire

// ### rtl/rx_frame_filter.sv
// Operation
// - Receiver becomes ready 192 us after reception is enabled.
// - After a frame, SFD search is blanked 192 us unless turnaround skip cleared.
// - Preamble and SFD never reach the FIFO; storage starts at length byte.
// - Byte after SFD is the length; frame ends after that many bytes.
// - SFD accepted when correlation meets threshold, after required preamble symbols.
// - Filter disabled accepts all frames; enabled (default) applies every check.
// - Reject frames shorter than the minimum implied by address modes.
// - Frame control bits 9..7 masked by reserved mask must be zero.
// - Reject frames whose version exceeds the highest accepted version.
// - Reject frames using reserved addressing mode 1.
// - Present destination PAN must be local PAN or broadcast.
// - Short destination is local or broadcast; extended must match exactly.
// - Beacons need enable, length 9, no destination, source, PAN match.
// - Data frames need enable, length 9, an address, coordinator rules.
// - Ack frames need enable and length exactly 5.
// - Command frames follow data conditions with their own enable.
// - Reserved types need their enable (reset 0) and length 9.
// - Filter ignores length bit 7 and may override frame type MSB.
// - Rejected frames are consumed to their end before searching again.
// - Accept event only with filter on and no overflow or abort first.
// - Live SFD bit high from SFD until last byte or rejection.
// - Sticky SFD flag until software clears; routable to pin or groups.
`default_nettype none
module rx_frame_filter
  import rx_filt_pkg::*;
#(
  parameter int unsigned TURN_CYC = rx_filt_pkg::TURNAROUND_CYC
) (
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O,
  input  wire logic [7:0]  DM_CORR_I,
  input  wire logic        DM_SYM_VALID_I,
  input  wire logic        DM_PREAMBLE_I,
  input  wire logic        DM_SFD_I,
  input  wire logic        DM_BYTE_VALID_I,
  input  wire logic [7:0]  DM_BYTE_I,
  input  wire logic        OVERFLOW_I,
  input  wire logic        ABORT_I,
  output logic             FIFO_WE_O,
  output logic [7:0]       FIFO_DATA_O,
  output logic             FIFO_DISCARD_O,
  output logic             FRAME_ACCEPTED_O,
  output logic             SFD_LIVE_O,
  output logic             SFD_PIN_O,
  output logic             GROUP_A_O,
  output logic             GROUP_B_O,
  output logic             RX_READY_O
);
  import rx_filt_pkg::*;

  localparam logic [15:0] TURN_W = TURN_CYC[15:0];

  typedef logic [22:0][7:0] hdr_t;

  typedef struct packed {
    rx_state_t   st;
    logic [15:0] tcnt;
    logic [3:0]  pre_cnt;
    logic [7:0]  len_raw;
    logic [7:0]  rem;
    logic [6:0]  cnt;
    hdr_t        hdr;
    logic        decided;
    logic        ovf_seen;
    logic        rxen;
    logic        skip;
    logic [7:0]  thr;
    logic [3:0]  pre_req;
    logic        fen;
    logic        coord;
    logic [2:0]  mask;
    logic [1:0]  maxver;
    logic [4:0]  acc;
    logic [1:0]  ovr;
    logic [15:0] panid;
    logic [15:0] short_addr;
    logic [63:0] ext_addr;
    logic [2:0]  route;
    logic        sfd_flag;
    logic        acc_flag;
    logic        ack;
    logic [31:0] dat;
    logic        fifo_we;
    logic [7:0]  fifo_data;
    logic        discard;
    logic        acc_pulse;
    logic        sfd_live;
    logic        pin;
    logic        grp_a;
    logic        grp_b;
    logic        ready;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  function automatic logic [15:0] get16(input hdr_t h, input logic [4:0] i);
    get16 = {h[i + 5'd1], h[i]};
  endfunction : get16

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] w,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? w[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction : merge

  // Header parse; the MSB override affects only the filter's view
  logic [15:0] fcf;
  logic [2:0]  ftype;
  logic [1:0]  dmode;
  logic [1:0]  smode;
  logic [4:0]  dpanlen;
  logic [4:0]  dlen;
  logic [4:0]  spanlen;
  logic [4:0]  slen;
  logic [4:0]  spanoff;
  logic [4:0]  hlen;
  logic [6:0]  len7;
  logic [15:0] dpan;
  logic [15:0] span;
  logic [15:0] dshort;
  logic [63:0] dext;
  logic        ok_min;
  logic        ok_res;
  logic        ok_ver;
  logic        ok_mode;
  logic        ok_dpan;
  logic        ok_dadr;
  logic        ok_type;
  logic        addr_rule;
  logic        pass;
  logic        ready_dec;
  logic        accept_now;
  logic        reject_now;

  assign fcf     = {s_ff.hdr[1], s_ff.hdr[0]};
  assign dmode   = fcf[11:10];
  assign smode   = fcf[15:14];
  assign len7    = s_ff.len_raw[6:0];
  always_comb begin
    ftype = fcf[2:0];
    unique case (s_ff.ovr)
      2'h1:    ftype[2] = ~fcf[2];
      2'h2:    ftype[2] = 1'b0;
      2'h3:    ftype[2] = 1'b1;
      default: ftype[2] = fcf[2];
    endcase
  end
  assign dpanlen = (dmode != 2'h0) ? 5'd2 : 5'd0;
  assign dlen    = (dmode == 2'h3) ? 5'd8 : ((dmode == 2'h2) ? 5'd2 : 5'd0);
  assign slen    = (smode == 2'h3) ? 5'd8 : ((smode == 2'h2) ? 5'd2 : 5'd0);
  assign spanlen = (smode != 2'h0 && !(fcf[6] && dmode != 2'h0)) ? 5'd2 : 5'd0;
  assign spanoff = 5'd3 + dpanlen + dlen;
  assign hlen    = spanoff + spanlen + slen;
  assign dpan    = get16(s_ff.hdr, 5'd3);
  assign dshort  = get16(s_ff.hdr, 5'd5);
  assign span    = (spanlen != 5'd0) ? get16(s_ff.hdr, spanoff) : dpan;
  assign dext    = {s_ff.hdr[12], s_ff.hdr[11], s_ff.hdr[10], s_ff.hdr[9],
                    s_ff.hdr[8], s_ff.hdr[7], s_ff.hdr[6], s_ff.hdr[5]};

  assign ok_min  = {1'b0, len7} >= ({3'b000, hlen} + 8'd2);
  assign ok_res  = (fcf[9:7] & s_ff.mask) == 3'b000;
  assign ok_ver  = fcf[13:12] <= s_ff.maxver;
  assign ok_mode = dmode != 2'h1 && smode != 2'h1;
  assign ok_dpan = dmode == 2'h0 || dpan == s_ff.panid || dpan == BCAST;
  assign ok_dadr = (dmode == 2'h2) ? (dshort == s_ff.short_addr || dshort == BCAST) :
                   (dmode == 2'h3) ? (dext == s_ff.ext_addr) : 1'b1;
  assign addr_rule = (dmode != 2'h0 || smode != 2'h0) &&
                     (dmode != 2'h0 || (s_ff.coord && span == s_ff.panid));
  always_comb begin
    unique case (ftype)
      3'h0: ok_type = s_ff.acc[0] && len7 >= LEN_MIN && dmode == 2'h0 && smode[1] &&
                      (span == s_ff.panid || s_ff.panid == BCAST);
      3'h1: ok_type = s_ff.acc[1] && len7 >= LEN_MIN && addr_rule;
      3'h2: ok_type = s_ff.acc[2] && len7 == LEN_ACK;
      3'h3: ok_type = s_ff.acc[3] && len7 >= LEN_MIN && addr_rule;
      default: ok_type = s_ff.acc[4] && len7 >= LEN_MIN;
    endcase
  end
  assign pass = ok_min && ok_res && ok_ver && ok_mode && ok_dpan && ok_dadr && ok_type;
  assign ready_dec  = (s_ff.cnt >= 7'd2 && s_ff.cnt >= {2'b00, hlen}) || s_ff.rem == 8'h00;
  assign accept_now = s_ff.st == ST_BODY && !s_ff.decided && ready_dec &&
                      (!s_ff.fen || pass);
  assign reject_now = s_ff.st == ST_BODY && !s_ff.decided && ready_dec && s_ff.fen && !pass;

  logic        req;
  logic [7:0]  badr;
  logic [31:0] rd;
  logic [31:0] wv;

  assign req  = CYC_I && STB_I && !s_ff.ack;
  assign badr = {ADR_I[7:2], 2'b00};
  always_comb begin
    unique case (badr)
      ADR_CTRL:   rd = {30'h0, s_ff.skip, s_ff.rxen};
      ADR_DEMOD:  rd = {20'h0, s_ff.pre_req, s_ff.thr};
      ADR_FILT0:  rd = {25'h0, s_ff.maxver, s_ff.mask, s_ff.coord, s_ff.fen};
      ADR_FILT1:  rd = {25'h0, s_ff.ovr, s_ff.acc};
      ADR_PANID:  rd = {16'h0, s_ff.panid};
      ADR_SHORT:  rd = {16'h0, s_ff.short_addr};
      ADR_EXTLO:  rd = s_ff.ext_addr[31:0];
      ADR_EXTHI:  rd = s_ff.ext_addr[63:32];
      ADR_STATUS: rd = {28'h0, s_ff.st == ST_DROP, s_ff.st == ST_BODY || s_ff.st == ST_LEN,
                        RX_READY_O, s_ff.sfd_live};
      ADR_EVENT:  rd = {30'h0, s_ff.acc_flag, s_ff.sfd_flag};
      ADR_ROUTE:  rd = {29'h0, s_ff.route};
      default:    rd = 32'h0;
    endcase
  end
  assign wv = merge(rd, DAT_I, SEL_I);

  always_comb begin
    logic sfd_ok;
    logic frame_end;
    logic ev_clr_sfd;
    logic ev_clr_acc;
    nxt_s = s_ff;
    sfd_ok = 1'b0;
    frame_end = 1'b0;
    ev_clr_sfd = 1'b0;
    ev_clr_acc = 1'b0;
    nxt_s.fifo_we = 1'b0;
    nxt_s.discard = 1'b0;
    nxt_s.acc_pulse = 1'b0;
    nxt_s.ack = req;
    nxt_s.dat = req ? rd : 32'h0;
    if (req && WE_I) begin
      unique case (badr)
        ADR_CTRL: begin
          nxt_s.rxen = wv[CTRL_RXEN_B];
          nxt_s.skip = wv[CTRL_SKIP_B];
        end
        ADR_DEMOD: begin
          nxt_s.thr = wv[DEM_THR_LSB +: 8];
          nxt_s.pre_req = wv[DEM_PRE_LSB +: 4];
        end
        ADR_FILT0: begin
          nxt_s.fen = wv[F0_EN_B];
          nxt_s.coord = wv[F0_COORD_B];
          nxt_s.mask = wv[F0_MASK_LSB +: 3];
          nxt_s.maxver = wv[F0_VER_LSB +: 2];
        end
        ADR_FILT1: begin
          nxt_s.acc = wv[F1_ACC_LSB +: 5];
          nxt_s.ovr = wv[F1_OVR_LSB +: 2];
        end
        ADR_PANID: nxt_s.panid = wv[15:0];
        ADR_SHORT: nxt_s.short_addr = wv[15:0];
        ADR_EXTLO: nxt_s.ext_addr[31:0] = wv;
        ADR_EXTHI: nxt_s.ext_addr[63:32] = wv;
        ADR_EVENT: begin
          ev_clr_sfd = DAT_I[EV_SFD_B] && SEL_I[0];
          ev_clr_acc = DAT_I[EV_ACC_B] && SEL_I[0];
        end
        ADR_ROUTE: nxt_s.route = wv[2:0];
        default: ;
      endcase
    end

    if (s_ff.tcnt != 16'h0) begin
      nxt_s.tcnt = s_ff.tcnt - 16'h1;
    end

    unique case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.rxen) begin
          nxt_s.st = ST_SEARCH;
          nxt_s.tcnt = TURN_W;
          nxt_s.pre_cnt = 4'h0;
        end
      end
      ST_SEARCH: begin
        if (DM_SYM_VALID_I) begin
          if (DM_PREAMBLE_I && DM_CORR_I >= s_ff.thr) begin
            nxt_s.pre_cnt = (s_ff.pre_cnt == 4'hf) ? 4'hf : s_ff.pre_cnt + 4'h1;
          end else begin
            nxt_s.pre_cnt = 4'h0;
          end
        end
        // Blanking reuses the warm-up counter, so both gate search alike
        sfd_ok = DM_SFD_I && s_ff.tcnt == 16'h0 && DM_CORR_I >= s_ff.thr &&
                 s_ff.pre_cnt >= s_ff.pre_req;
        if (!s_ff.rxen) begin
          nxt_s.st = ST_IDLE;
        end else if (sfd_ok) begin
          nxt_s.st = ST_LEN;
          nxt_s.sfd_live = 1'b1;
          nxt_s.pre_cnt = 4'h0;
        end
      end
      ST_LEN: begin
        if (DM_BYTE_VALID_I) begin
          nxt_s.len_raw = DM_BYTE_I;
          nxt_s.rem = DM_BYTE_I;
          nxt_s.cnt = 7'h0;
          nxt_s.decided = 1'b0;
          nxt_s.ovf_seen = 1'b0;
          nxt_s.fifo_we = 1'b1;
          nxt_s.fifo_data = DM_BYTE_I;
          nxt_s.st = ST_BODY;
        end
      end
      ST_BODY: begin
        if (DM_BYTE_VALID_I && s_ff.rem != 8'h00) begin
          if (s_ff.cnt < HDR_BYTES) begin
            nxt_s.hdr[s_ff.cnt[4:0]] = DM_BYTE_I;
          end
          nxt_s.cnt = (s_ff.cnt == 7'h7f) ? s_ff.cnt : s_ff.cnt + 7'h1;
          nxt_s.rem = s_ff.rem - 8'h1;
          nxt_s.fifo_we = 1'b1;
          nxt_s.fifo_data = DM_BYTE_I;
        end
        if (accept_now) begin
          nxt_s.decided = 1'b1;
          nxt_s.acc_pulse = s_ff.fen && !s_ff.ovf_seen && !OVERFLOW_I;
        end
        if (reject_now) begin
          nxt_s.sfd_live = 1'b0;
          nxt_s.discard = 1'b1;
          nxt_s.fifo_we = 1'b0;
          if (s_ff.rem == 8'h00) begin
            frame_end = 1'b1;
          end else begin
            nxt_s.st = ST_DROP;
          end
        end else if (s_ff.rem == 8'h00 && (s_ff.decided || accept_now)) begin
          frame_end = 1'b1;
        end
      end
      ST_DROP: begin
        if (DM_BYTE_VALID_I && s_ff.rem != 8'h00) begin
          nxt_s.rem = s_ff.rem - 8'h1;
        end
        if (s_ff.rem == 8'h00) begin
          frame_end = 1'b1;
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase

    if (OVERFLOW_I) begin
      nxt_s.ovf_seen = 1'b1;
    end
    // Abort ends the frame at once; no event may follow it
    if (ABORT_I && (s_ff.st == ST_LEN || s_ff.st == ST_BODY || s_ff.st == ST_DROP)) begin
      frame_end = 1'b1;
      nxt_s.acc_pulse = 1'b0;
      nxt_s.fifo_we = 1'b0;
    end
    if (frame_end) begin
      nxt_s.st = ST_SEARCH;
      nxt_s.sfd_live = 1'b0;
      nxt_s.tcnt = s_ff.skip ? TURN_W : 16'h0;
      nxt_s.pre_cnt = 4'h0;
    end

    // Set wins over a software clear in the same cycle
    nxt_s.sfd_flag = (s_ff.sfd_flag && !ev_clr_sfd) || sfd_ok;
    nxt_s.acc_flag = (s_ff.acc_flag && !ev_clr_acc) || nxt_s.acc_pulse;
    nxt_s.pin = nxt_s.sfd_flag && nxt_s.route[0];
    nxt_s.grp_a = nxt_s.sfd_flag && nxt_s.route[1];
    nxt_s.grp_b = nxt_s.sfd_flag && nxt_s.route[2];
    // Ready is registered from the next state so the pin needs no decode
    nxt_s.ready = nxt_s.st == ST_SEARCH && nxt_s.tcnt == 16'h0;
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.rxen <= RST_RXEN;
      s_ff.skip <= RST_SKIP;
      s_ff.thr <= RST_THR;
      s_ff.pre_req <= RST_PRE;
      s_ff.fen <= RST_FEN;
      s_ff.coord <= RST_COORD;
      s_ff.mask <= RST_MASK;
      s_ff.maxver <= RST_VER;
      s_ff.acc <= RST_ACC;
      s_ff.ovr <= RST_OVR;
      s_ff.route <= RST_ROUTE;
      s_ff.decided <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign DAT_O            = s_ff.dat;
  assign ACK_O            = s_ff.ack;
  assign FIFO_WE_O        = s_ff.fifo_we;
  assign FIFO_DATA_O      = s_ff.fifo_data;
  assign FIFO_DISCARD_O   = s_ff.discard;
  assign FRAME_ACCEPTED_O = s_ff.acc_pulse;
  assign SFD_LIVE_O       = s_ff.sfd_live;
  assign SFD_PIN_O        = s_ff.pin;
  assign GROUP_A_O        = s_ff.grp_a;
  assign GROUP_B_O        = s_ff.grp_b;
  assign RX_READY_O       = s_ff.ready;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  warmup_load_a: assert property (
    s_ff.st == ST_IDLE && s_ff.rxen |=> s_ff.tcnt == TURN_W && !RX_READY_O)
    else $error("warm-up count not loaded on enable");
  blank_load_a: assert property (
    $fell(SFD_LIVE_O) && s_ff.st == ST_SEARCH && $past(s_ff.skip) |-> s_ff.tcnt == TURN_W)
    else $error("turnaround blanking missing after frame");
  fifo_scope_a: assert property (
    FIFO_WE_O |-> $past(s_ff.st) == ST_LEN || $past(s_ff.st) == ST_BODY)
    else $error("FIFO written outside length and body");
  length_take_a: assert property (
    s_ff.st == ST_LEN && DM_BYTE_VALID_I && !ABORT_I |=> s_ff.rem == $past(DM_BYTE_I))
    else $error("length byte not taken as remaining count");
  sfd_threshold_a: assert property (
    $rose(SFD_LIVE_O) |-> $past(DM_CORR_I) >= $past(s_ff.thr) &&
                          $past(s_ff.pre_cnt) >= $past(s_ff.pre_req))
    else $error("SFD accepted below threshold");
  filter_off_a: assert property (
    s_ff.st == ST_BODY && !s_ff.fen |=> !FIFO_DISCARD_O)
    else $error("frame rejected with filter off");
  reserved_mode_a: assert property (
    reject_now == 1'b0 && accept_now && s_ff.fen |-> dmode != 2'h1 && smode != 2'h1)
    else $error("reserved address mode accepted");
  ack_length_a: assert property (
    accept_now && s_ff.fen && ftype == 3'h2 |-> len7 == LEN_ACK)
    else $error("ack accepted with wrong length");
  drop_window_a: assert property (
    s_ff.st == ST_DROP && s_ff.rem != 8'h00 && !ABORT_I |=> s_ff.st == ST_DROP && !SFD_LIVE_O)
    else $error("search resumed inside rejected frame");
  accept_event_a: assert property (
    FRAME_ACCEPTED_O |-> $past(s_ff.fen) && !$past(s_ff.ovf_seen) && !$past(OVERFLOW_I))
    else $error("accept event without filter or after overflow");
  live_reject_a: assert property (
    reject_now |=> !SFD_LIVE_O && FIFO_DISCARD_O)
    else $error("live SFD not dropped on rejection");
  flag_sticky_a: assert property (
    s_ff.sfd_flag && !(req && WE_I && badr == ADR_EVENT) |=> s_ff.sfd_flag)
    else $error("SFD flag lost without clear");

  accept_c: cover property (FRAME_ACCEPTED_O);
  reject_c: cover property (FIFO_DISCARD_O);
  blank_c:  cover property ($fell(SFD_LIVE_O) ##1 s_ff.tcnt != 16'h0);
  abort_c:  cover property (ABORT_I && s_ff.st == ST_BODY);
endmodule : rx_frame_filter
`default_nettype wire

// ### verif/dm_model.sv
`default_nettype none
module dm_model (
  input  wire logic       clk_i,
  output logic [7:0]      corr_o,
  output logic            sym_o,
  output logic            pre_o,
  output logic            sfd_o,
  output logic            bv_o,
  output logic [7:0]      byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    corr_o = '0;
    {sym_o, pre_o, sfd_o, bv_o} = '0;
    byte_o = '0;
  end
  // Bytes go two cycles apart; between them the line shows the inverse, never a held value
  task automatic send(input int np, input logic [7:0] c, input logic [7:0] q[$]);
    repeat (np) begin
      @(posedge clk_i);
      sym_o <= 1'b1;
      pre_o <= 1'b1;
      corr_o <= c;
      @(posedge clk_i);
      sym_o <= 1'b0;
      pre_o <= 1'b0;
    end
    @(posedge clk_i);
    sfd_o <= 1'b1;
    corr_o <= c;
    @(posedge clk_i);
    sfd_o <= 1'b0;
    foreach (q[i]) begin
      @(posedge clk_i);
      bv_o <= 1'b1;
      byte_o <= q[i];
      @(posedge clk_i);
      bv_o <= 1'b0;
      byte_o <= ~q[i];
    end
  endtask : send
endmodule : dm_model
`default_nettype wire

// ### verif/tb.sv
`default_nettype none
module tb;
  import rx_filt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TC = 16;
  typedef logic [7:0] bq_t[$];
  logic clk, rst_n, cyc, stb, we, ovf, abt, ack, fwe, fdis, facc, live, pin, ga, gb, rdy;
  logic sym, pre, sfd, bv, fen;
  logic [7:0] adr, fdat, corr, bt;
  logic [3:0] sel;
  logic [4:0] acc;
  logic [31:0] wd, rd, dat_o;
  bq_t got;
  int n_errors, samples_checked, na, nd, lv, cycles, n;
  rx_frame_filter #(.TURN_CYC(TC)) i_rx_frame_filter (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wd), .DAT_O(dat_o),
    .ACK_O(ack), .DM_CORR_I(corr), .DM_SYM_VALID_I(sym), .DM_PREAMBLE_I(pre), .DM_SFD_I(sfd),
    .DM_BYTE_VALID_I(bv), .DM_BYTE_I(bt), .OVERFLOW_I(ovf), .ABORT_I(abt), .FIFO_WE_O(fwe),
    .FIFO_DATA_O(fdat), .FIFO_DISCARD_O(fdis), .FRAME_ACCEPTED_O(facc), .SFD_LIVE_O(live),
    .SFD_PIN_O(pin), .GROUP_A_O(ga), .GROUP_B_O(gb), .RX_READY_O(rdy));
  dm_model i_dm_model (.clk_i(clk), .corr_o(corr), .sym_o(sym), .pre_o(pre), .sfd_o(sfd),
    .bv_o(bv), .byte_o(bt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cycles++;
    if (fwe === 1'b1) got.push_back(fdat);
    na += int'(facc === 1'b1);
    nd += int'(fdis === 1'b1);
    if (live === 1'b1) lv = 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction : rb
  function automatic bq_t mk(input logic [15:0] sh);
    return '{8'h09, 8'h01, 8'h08, rb(), 8'h34, 8'h12, sh[7:0], sh[15:8], rb(), rb()};
  endfunction : mk
  // 0 no event, 1 accept, 2 discard
  function automatic int exp_res(input bq_t q);
    logic [15:0] f, p, s;
    logic [6:0] l;
    logic ok;
    l = q[0][6:0];
    f = {q[2], q[1]};
    p = {q[5], q[4]};
    s = {q[7], q[6]};
    if (!fen) return 0;
    case (f[2:0])
      3'd1: ok = acc[1] && l >= 9 && f[11:10] == 2'd2 && (p == 16'h1234 || p == BCAST)
                 && (s == 16'h0042 || s == BCAST);
      3'd2: ok = acc[2] && l == 7'd5;
      3'd0, 3'd3: ok = 1'b0;
      default: ok = acc[4] && l >= 9;
    endcase
    return ok ? 1 : 2;
  endfunction : exp_res
  task automatic frm(input int g, input int np, input logic [7:0] c, input bq_t q,
                     input logic sf, input int ov);
    int a;
    repeat (g) @(posedge clk);
    got.delete();
    {na, nd, lv} = '0;
    fork
      i_dm_model.send(np, c, q);
      if (ov != 0) begin
        repeat (np * 2 + 4) @(posedge clk);
        if (ov == 1) ovf <= 1'b1;
        else abt <= 1'b1;
        @(posedge clk);
        ovf <= 1'b0;
        abt <= 1'b0;
      end
    join
    repeat (6) @(posedge clk);
    a = sf ? exp_res(q) : 0;
    if (ov == 2 || (ov == 1 && a == 1)) a = 0;
    chk(lv, sf);
    chk(live, 0);
    if (a != 2) chk(got.size(), !sf ? 0 : (ov == 2) ? 1 : q.size());
    foreach (got[i]) chk(got[i], q[i]);
    chk(na, a == 1);
    chk(nd, a == 2);
  endtask : frm
  initial begin
    {rst_n, cyc, stb, we, ovf, abt} = '0;
    {adr, sel, wd, n_errors, samples_checked, cycles} = '0;
    fen = 1'b1;
    acc = RST_ACC;
    void'($urandom(32'hc76d));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wb(0, ADR_FILT0, 0);
    chk(rd, 32'h7d);
    wb(0, ADR_FILT1, 0);
    chk(rd, 32'h0f);
    wb(0, ADR_STATUS, 0);
    chk(rd, 0);
    wb(1, ADR_PANID, 32'h1234);
    wb(1, ADR_SHORT, 32'h0042);
    wb(1, ADR_CTRL, 32'h3);
    n = 0;
    while (rdy !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n, TC);
    frm(0, 0, 8'h30, mk(16'h0042), 1, 0);
    chk(pin, 1);
    for (int i = 0; i < 8; i++)
      frm(TC + 4, 0, 8'h14 + rb() % 64, mk(i[0] ? BCAST : 16'(rb())), 1, 0);
    frm(TC + 4, 0, 8'h30, '{8'h05, 8'h02, 8'h00, rb(), rb(), rb()}, 1, 0);
    frm(TC + 4, 0, 8'h30, '{8'h06, 8'h02, 8'h00, rb(), rb(), rb(), rb()}, 1, 0);
    frm(TC + 4, 0, 8'h30, '{8'h09, 8'h04, 8'h00, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7}, 1, 0);
    wb(1, ADR_FILT1, 32'h1f);
    acc = 5'h1f;
    frm(TC + 4, 0, 8'h30, '{8'h09, 8'h04, 8'h00, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6, 8'h7}, 1, 0);
    frm(TC + 4, 0, 8'h30, mk(16'h0042), 1, 1);
    frm(TC + 4, 0, 8'h30, mk(16'h0042), 1, 2);
    frm(TC + 4, 0, 8'h10, mk(16'h0042), 0, 0);
    wb(1, ADR_DEMOD, 32'h0414);
    frm(TC + 4, 2, 8'h30, mk(16'h0042), 0, 0);
    frm(TC + 4, 5, 8'h30, mk(16'h0042), 1, 0);
    wb(1, ADR_DEMOD, 32'h0014);
    frm(2, 0, 8'h30, mk(16'h0042), 0, 0);
    wb(1, ADR_CTRL, 32'h1);
    frm(TC + 4, 0, 8'h30, mk(16'h0042), 1, 0);
    frm(2, 0, 8'h30, mk(16'h0042), 1, 0);
    wb(1, ADR_EVENT, 32'h3);
    chk(pin, 0);
    wb(1, ADR_ROUTE, 32'h6);
    frm(TC + 4, 0, 8'h30, mk(16'h0042), 1, 0);
    chk({ga, gb, pin}, 3'b110);
    wb(1, ADR_FILT0, 32'h7c);
    fen = 1'b0;
    frm(TC + 4, 0, 8'h30, mk(16'h0077), 1, 0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
